// ### rtl/gated_counter_defines.vh
// constants for the gated sixteen bit counter block
`ifndef GATED_COUNTER_DEFINES_VH
`define GATED_COUNTER_DEFINES_VH
// register byte addresses
`define ADDR_COUNTER_CONTROL 6'h00
`define ADDR_PIN_STEERING 6'h04
`define ADDR_COUNT_LOW 6'h08
`define ADDR_COUNT_HIGH 6'h0c
`define ADDR_COMPARE_LOW 6'h10
`define ADDR_COMPARE_HIGH 6'h14
`define ADDR_COMPARATOR_CTRL 6'h18
`define ADDR_IRQ_STATUS 6'h1c
`define ADDR_IRQ_ENABLE 6'h20
`define ADDR_IRQ_CLEAR 6'h24
// counter_control fields
`define CTL_GATE_POLARITY 7
`define CTL_GATE_ENABLE 6
`define CTL_PRESCALE_HI 5
`define CTL_PRESCALE_LO 4
`define CTL_LP_OSC_ENABLE 3
`define CTL_SYNC_DISABLE 2
`define CTL_CLOCK_SOURCE 1
`define CTL_COUNTER_ON 0
// alternate_pin_steering fields
`define STEER_GATE_PIN 4
`define STEER_MASK 8'h13
// comparator_control_two fields
`define CMP_ALT_CLOCK 4
`define CMP_GATE_SOURCE 1
`define CMP_SYNC 0
`define CMP_MASK 8'h13
// compare unit mode: special event trigger when this bit is set
`define CMP_SPECIAL_EVENT 7
// reset values
`define RESET_BYTE 8'h00
// interrupt bits
`define IRQ_OVERFLOW 0
`define IRQ_SPECIAL 1
`endif

// ### rtl/edge_sync.v
// two-stage synchroniser with a rising edge detect on the safe stage
`default_nettype none
module edge_sync (
    input wire clk,
    input wire sys_rst,
    input wire asyncIn,
    output wire syncOut,
    output wire riseOut
);
    reg metaFf; // first stage, read only by stageFf
    reg stageFf; // safe synchronised level
    reg lastFf; // previous safe level for the edge detect

    // two flops then one more for edge detection
    always @(posedge clk) begin
        if (sys_rst) begin
            metaFf <= 1'b0;
            stageFf <= 1'b0;
            lastFf <= 1'b0;
        end else begin
            metaFf <= asyncIn;
            stageFf <= metaFf;
            lastFf <= stageFf;
        end
    end

    assign syncOut = stageFf;
    assign riseOut = stageFf & ~lastFf;
endmodule
`default_nettype wire

// ### rtl/gated_sixteen_bit_counter.v
// gated sixteen bit counter with axi4-lite register access
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
`include "gated_counter_defines.vh"
module gated_sixteen_bit_counter #(
    parameter PRESCALE_BITS = 3
) (
    input wire clk,
    input wire sys_rst,
    // axi4-lite slave
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // outside pins and neighbours
    input wire externalCountPin,
    input wire gatePinDefault,
    input wire gatePinAlternate,
    input wire comparatorOutput,
    input wire instrClockTick,
    input wire internalOscNoClkout,
    input wire specialEventTrigger,
    output reg lowPowerOscOn,
    output reg irq
);
    // writable state
    reg [7:0] controlFf; // counter_control
    reg [7:0] steerFf; // alternate_pin_steering
    reg [7:0] cmpCtlFf; // comparator_control_two copy
    reg [7:0] compareLowFf; // compare_value_low
    reg [7:0] compareHighFf; // compare_value_high, bit usage below
    reg [7:0] eccpModeFf; // compare unit mode bits
    reg [15:0] countFf; // count_high_byte:count_low_byte
    reg [15:0] nxt_count;
    reg [PRESCALE_BITS-1:0] prescaleFf; // prescaler ripple
    reg [PRESCALE_BITS-1:0] nxt_prescale;
    reg [1:0] irqStatusFf; // sticky events
    reg [1:0] irqEnableFf; // event enables
    reg [1:0] nxt_status;
    reg cmpHoldFf; // comparator latched on count clock
    reg trigLastFf; // special event edge detect
    // bus holding registers
    reg awHeldFf;
    reg wHeldFf;
    reg [5:0] awAddrFf;
    reg [31:0] wDataFf;
    reg [3:0] wStrbFf;

    // synchronised pins
    wire extSync;
    wire extRise;
    wire gateDefSync;
    wire gateAltSync;
    wire cmpSync;
    reg extRawLastFf; // previous extFastFf level for the unsynchronised edge detect
    reg extMetaFf; // first stage for the unsynchronised path
    reg extFastFf; // second stage, keeps the 2-flop discipline

    edge_sync extSyncInst (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(externalCountPin),
        .syncOut(extSync),
        .riseOut(extRise)
    );
    edge_sync gateDefInst (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(gatePinDefault),
        .syncOut(gateDefSync),
        .riseOut()
    );
    edge_sync gateAltInst (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(gatePinAlternate),
        .syncOut(gateAltSync),
        .riseOut()
    );
    edge_sync cmpInst (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(comparatorOutput),
        .syncOut(cmpSync),
        .riseOut()
    );

    // unsynchronised mode still passes two flops and an edge stage, the same
    // depth as edge_sync, so its edges arrive no earlier than the synchronised ones
    always @(posedge clk) begin
        if (sys_rst) begin
            extMetaFf <= 1'b0;
            extFastFf <= 1'b0;
            extRawLastFf <= 1'b0;
        end else begin
            extMetaFf <= externalCountPin;
            extFastFf <= extMetaFf;
            extRawLastFf <= extFastFf;
        end
    end

    // control field decode
    wire counterOn = controlFf[`CTL_COUNTER_ON];
    wire extSelect = controlFf[`CTL_CLOCK_SOURCE];
    wire syncOff = controlFf[`CTL_SYNC_DISABLE];
    wire gateEnable = controlFf[`CTL_GATE_ENABLE];
    wire gatePolarity = controlFf[`CTL_GATE_POLARITY];
    wire [1:0] prescaleSel =
        controlFf[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];

    // raw count clock edges
    wire extFastRise = extFastFf & ~extRawLastFf;
    wire extEdge = syncOff ? extFastRise : extRise;
    wire clockEdge = extSelect ? extEdge : instrClockTick;

    // prescaler output pulse
    reg prescaleTick;
    always @* begin
        case (prescaleSel)
            2'h0: prescaleTick = clockEdge;
            2'h1: prescaleTick = clockEdge & prescaleFf[0];
            2'h2: prescaleTick = clockEdge & (&prescaleFf[1:0]);
            default: prescaleTick = clockEdge & (&prescaleFf[2:0]);
        endcase
    end

    // gate source and level
    wire gatePin = steerFf[`STEER_GATE_PIN] ?
        gateAltSync : gateDefSync;
    // comparator form: latched on count clock when its sync is on
    wire cmpForGate = cmpCtlFf[`CMP_SYNC] ? cmpHoldFf : cmpSync;
    wire gateRaw = cmpCtlFf[`CMP_GATE_SOURCE] ?
        cmpForGate : gatePin;
    wire gateActive = gatePolarity ? gateRaw : ~gateRaw;
    wire runAllowed = counterOn &
        (~gateEnable | gateActive);
    wire countStep = runAllowed & prescaleTick;

    // special event: rising edge of trigger while mode enabled
    wire specialMode = eccpModeFf[`CMP_SPECIAL_EVENT];
    wire trigPulse = specialEventTrigger & ~trigLastFf & specialMode;
    wire [15:0] compareValue = {compareHighFf, compareLowFf};
    // period match behaves like the compare unit firing itself
    wire periodHit = specialMode & countStep &
        (countFf == compareValue);
    wire specialClear = trigPulse | periodHit;

    // bus write decode
    wire wrFire = awHeldFf & wHeldFf & ~s_axi_bvalid;
    wire wrByte = wrFire & wStrbFf[0];
    wire wrCountLow = wrByte & (awAddrFf == `ADDR_COUNT_LOW);
    wire wrCountHigh = wrByte & (awAddrFf == `ADDR_COUNT_HIGH);

    // next count value
    always @* begin
        nxt_count = countFf;
        nxt_prescale = prescaleFf;
        if (clockEdge & counterOn) begin
            nxt_prescale = prescaleFf + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
        end
        if (countStep) begin
            nxt_count = countFf + 16'h0001;
        end
        if (specialClear & ~wrCountLow & ~wrCountHigh) begin
            nxt_count = 16'h0000;
        end
        // software write takes precedence over the clear
        if (wrCountLow) begin
            nxt_count[7:0] = wDataFf[7:0];
        end
        if (wrCountHigh) begin
            nxt_count[15:8] = wDataFf[7:0];
        end
    end

    // sticky events; set wins over clear
    always @* begin
        nxt_status = irqStatusFf;
        if (wrFire & wStrbFf[0] & (awAddrFf == `ADDR_IRQ_CLEAR)) begin
            nxt_status = irqStatusFf & ~wDataFf[1:0];
        end
        // overflow only from a real increment, never from a clear
        if (countStep & (countFf == 16'hffff) & ~specialClear
            & ~wrCountLow & ~wrCountHigh) begin
            nxt_status[`IRQ_OVERFLOW] = 1'b1;
        end
        if (specialClear) begin
            nxt_status[`IRQ_SPECIAL] = 1'b1;
        end
    end

    // counter datapath and registers
    always @(posedge clk) begin
        if (sys_rst) begin
            controlFf <= `RESET_BYTE;
            steerFf <= `RESET_BYTE;
            cmpCtlFf <= `RESET_BYTE;
            compareLowFf <= `RESET_BYTE;
            compareHighFf <= `RESET_BYTE;
            eccpModeFf <= `RESET_BYTE;
            countFf <= 16'h0000;
            prescaleFf <= {PRESCALE_BITS{1'b0}};
            irqStatusFf <= 2'h0;
            irqEnableFf <= 2'h0;
            cmpHoldFf <= 1'b0;
            trigLastFf <= 1'b0;
            lowPowerOscOn <= 1'b0;
            irq <= 1'b0;
        end else begin
            countFf <= nxt_count;
            prescaleFf <= counterOn ? nxt_prescale :
                {PRESCALE_BITS{1'b0}};
            irqStatusFf <= nxt_status;
            trigLastFf <= specialEventTrigger;
            // comparator sampled on the same edge that counts
            if (clockEdge) begin
                cmpHoldFf <= cmpSync;
            end
            lowPowerOscOn <= controlFf[`CTL_LP_OSC_ENABLE] &
                internalOscNoClkout;
            irq <= |(nxt_status & irqEnableFf);
            if (wrByte) begin
                case (awAddrFf)
                    `ADDR_COUNTER_CONTROL: controlFf <= wDataFf[7:0];
                    `ADDR_PIN_STEERING:
                        steerFf <= wDataFf[7:0] & `STEER_MASK;
                    `ADDR_COMPARE_LOW: compareLowFf <= wDataFf[7:0];
                    `ADDR_COMPARE_HIGH: compareHighFf <= wDataFf[7:0];
                    `ADDR_COMPARATOR_CTRL:
                        cmpCtlFf <= wDataFf[7:0] & `CMP_MASK;
                    `ADDR_IRQ_ENABLE: irqEnableFf <= wDataFf[1:0];
                    default: begin
                    end
                endcase
            end
            // compare unit mode shares the compare high word, byte 1
            if (wrFire & wStrbFf[1] & (awAddrFf == `ADDR_COMPARE_HIGH)) begin
                eccpModeFf <= wDataFf[15:8];
            end
        end
    end

    // address map check
    function mapped;
        input [5:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a[5:2] <= 4'h9);
        end
    endfunction

    // write channel: take address and data in either order
    always @(posedge clk) begin
        if (sys_rst) begin
            awHeldFf <= 1'b0;
            wHeldFf <= 1'b0;
            awAddrFf <= 6'h00;
            wDataFf <= 32'h00000000;
            wStrbFf <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= ~awHeldFf & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~wHeldFf & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHeldFf <= 1'b1;
                awAddrFf <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeldFf <= 1'b1;
                wDataFf <= s_axi_wdata;
                wStrbFf <= s_axi_wstrb;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddrFf) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHeldFf <= 1'b0;
                wHeldFf <= 1'b0;
            end
        end
    end

    // read channel: one cycle to accept, data the next
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
                case (s_axi_araddr)
                    `ADDR_COUNTER_CONTROL: s_axi_rdata <= {24'h0, controlFf};
                    `ADDR_PIN_STEERING: s_axi_rdata <= {24'h0, steerFf};
                    `ADDR_COUNT_LOW: s_axi_rdata <= {24'h0, countFf[7:0]};
                    `ADDR_COUNT_HIGH: s_axi_rdata <= {24'h0, countFf[15:8]};
                    `ADDR_COMPARE_LOW: s_axi_rdata <= {24'h0, compareLowFf};
                    `ADDR_COMPARE_HIGH:
                        s_axi_rdata <= {16'h0, eccpModeFf, compareHighFf};
                    `ADDR_COMPARATOR_CTRL: s_axi_rdata <= {24'h0, cmpCtlFf};
                    `ADDR_IRQ_STATUS: s_axi_rdata <= {30'h0, irqStatusFf};
                    `ADDR_IRQ_ENABLE: s_axi_rdata <= {30'h0, irqEnableFf};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/gated_counter_sva.sv
// assertion checker for the counter's bus outputs and its lowPowerOscOn pin
`default_nettype none
module gated_counter_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic internalOscNoClkout,
    input wire logic lowPowerOscOn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // answers stand until taken
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    // ready is a one-cycle pulse
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    // bounded answer times
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        |-> ##[1:4] s_axi_bvalid) else $error("no write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("no read answer");
    a_rvalid_cause: assert property ($rose(s_axi_rvalid)
        |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without request");
    // unmapped place answers with an error
    a_unmapped_err: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr > 6'h24 |-> ##[1:4] s_axi_bvalid
        && s_axi_bresp == 2'b10) else $error("unmapped write not refused");
    a_upper_zero: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0) else $error("upper read bits set");
    // oscillator stays off outside the internal mode
    a_lposc_off: assert property (!internalOscNoClkout
        |=> !lowPowerOscOn) else $error("oscillator on in wrong mode");
endmodule
bind gated_sixteen_bit_counter gated_counter_sva gated_counter_sva_inst (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .internalOscNoClkout, .lowPowerOscOn
);
`default_nettype wire

// ### sim/counter_pins_model.sv
// behavioural model of count pin, gate pins and comparator
`default_nettype none
module counter_pins_model (
    input wire logic clk,
    output logic extPin,
    output logic gateDef,
    output logic gateAlt,
    output logic cmpOut
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet levels at start; count pin idles low between bursts
    initial begin
        extPin = 1'b0;
        gateDef = 1'b0;
        gateAlt = 1'b0;
        cmpOut = 1'b0;
    end
    // slow edges so even the three-flop sync path sees each one
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            extPin <= 1'b1;
            repeat (4) @(posedge clk);
            extPin <= 1'b0;
        end
    endtask
    // new gate and comparator levels
    task automatic levels(input logic d, input logic a, input logic c);
        @(posedge clk);
        gateDef <= d;
        gateAlt <= a;
        cmpOut <= c;
    endtask
endmodule
`default_nettype wire

// ### sim/gated_sixteen_bit_counter_tb.sv
// self-checking bench for the gated sixteen bit counter
`default_nettype none
`include "gated_counter_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module gated_sixteen_bit_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0;
    logic sys_rst = 1;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 0;
    logic instrClockTick = 0, internalOscNoClkout = 0;
    logic specialEventTrigger = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, lowPowerOscOn, irq;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic externalCountPin, gatePinDefault, gatePinAlternate;
    wire logic comparatorOutput;
    int fails = 0, n_checks = 0;
    logic [31:0] rdat; // last read data
    logic [1:0] resp; // last response code
    always #5 clk = ~clk;
    gated_sixteen_bit_counter gated_sixteen_bit_counter_inst (
        .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .externalCountPin, .gatePinDefault,
        .gatePinAlternate, .comparatorOutput, .instrClockTick,
        .internalOscNoClkout, .specialEventTrigger, .lowPowerOscOn, .irq
    );
    counter_pins_model counter_pins_model_inst (
        .clk, .extPin(externalCountPin), .gateDef(gatePinDefault),
        .gateAlt(gatePinAlternate), .cmpOut(comparatorOutput)
    );
    // one write; each channel held until its own ready
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'h1);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read; rready held until the answer is sampled
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clk);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // internal count edges, spaced so none merge
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            instrClockTick <= 1'b1;
            @(posedge clk);
            instrClockTick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    // clear, run n edges under control c, stop, compare low byte
    task automatic cnt(input logic [7:0] c, input int n,
        input logic [7:0] e);
        wr(`ADDR_COUNT_LOW, 0);
        wr(`ADDR_COUNT_HIGH, 0);
        wr(`ADDR_COUNTER_CONTROL, {24'h0, c});
        if (c[`CTL_CLOCK_SOURCE]) counter_pins_model_inst.pulse(n);
        else tick(n);
        repeat (8) @(posedge clk);
        wr(`ADDR_COUNTER_CONTROL, 0);
        rd(`ADDR_COUNT_LOW);
        `CHK(rdat[7:0], e)
    endtask
    task automatic complete_run;
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #500000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ADDR_COUNTER_CONTROL);
        `CHK(rdat, 32'h0)
        wr(`ADDR_PIN_STEERING, 32'hff);
        rd(`ADDR_PIN_STEERING);
        `CHK(rdat, 32'h13)
        rd(6'h28);
        `CHK({resp, rdat}, 34'h200000000)
        wr(6'h28, 1);
        `CHK(resp, 2'b10)
        wr(`ADDR_PIN_STEERING, 0);
        counter_pins_model_inst.levels(1, 0, 0);
        cnt(8'h01, 8, 8);
        cnt(8'h00, 8, 0);
        for (int i = 0; i < 4; i++)
            cnt({2'b0, i[1:0], 4'h1}, 8, 8 >> i);
        cnt(8'hc1, 5, 5);
        cnt(8'h41, 5, 0);
        wr(`ADDR_PIN_STEERING, 32'h10);
        cnt(8'hc1, 5, 0);
        cnt(8'h41, 5, 5);
        wr(`ADDR_PIN_STEERING, 0);
        counter_pins_model_inst.levels(0, 0, 1);
        // comparator gate, plain then synchronised
        for (int s = 2; s < 4; s++) begin
            wr(`ADDR_COMPARATOR_CTRL, s);
            cnt(8'hc1, 5, 5);
            cnt(8'h41, 5, 0);
        end
        cnt(8'h01, 5, 5);
        wr(`ADDR_COMPARATOR_CTRL, 0);
        cnt(8'h03, 5, 5);
        cnt(8'h07, 5, 5);
        cnt(8'h05, 5, 5);
        // rollover, mask and clear of the interrupt
        wr(`ADDR_COUNT_LOW, 32'hff);
        wr(`ADDR_COUNT_HIGH, 32'hff);
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        wr(`ADDR_COUNTER_CONTROL, 32'h1);
        tick(1);
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b1)
        rd(`ADDR_IRQ_STATUS);
        `CHK(rdat, 32'h1)
        rd(`ADDR_COUNT_HIGH);
        `CHK(rdat, 32'h0)
        wr(`ADDR_IRQ_ENABLE, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(`ADDR_IRQ_CLEAR, 32'h1);
        // special event clears count without overflow flag
        wr(`ADDR_COMPARE_LOW, 32'hff);
        wr(`ADDR_COMPARE_HIGH, 32'h80ff, 4'h3);
        // a count write landing with a trigger keeps the written value
        wr(`ADDR_COUNT_HIGH, 32'h12);
        fork
            wr(`ADDR_COUNT_LOW, 32'h34);
            begin
                repeat (3) @(posedge clk);
                specialEventTrigger <= 1'b1;
                repeat (2) @(posedge clk);
                specialEventTrigger <= 1'b0;
            end
        join
        rd(`ADDR_COUNT_LOW);
        `CHK(rdat, 32'h34)
        rd(`ADDR_COUNT_HIGH);
        `CHK(rdat, 32'h12)
        @(posedge clk);
        specialEventTrigger <= 1'b1;
        repeat (3) @(posedge clk);
        specialEventTrigger <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b1)
        rd(`ADDR_COUNT_LOW);
        `CHK(rdat, 32'h0)
        rd(`ADDR_COUNT_HIGH);
        `CHK(rdat, 32'h0)
        rd(`ADDR_IRQ_STATUS);
        `CHK(rdat, 32'h2)
        wr(`ADDR_IRQ_CLEAR, 32'h3);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        // compare pair as period
        wr(`ADDR_COMPARE_LOW, 32'h3);
        wr(`ADDR_COMPARE_HIGH, 32'h8000, 4'h3);
        tick(7);
        rd(`ADDR_COUNT_LOW);
        `CHK(rdat, 32'h3)
        wr(`ADDR_COMPARE_HIGH, 0, 4'h3);
        wr(`ADDR_COUNTER_CONTROL, 32'h8);
        repeat (3) @(posedge clk);
        `CHK(lowPowerOscOn, 1'b0)
        internalOscNoClkout <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(lowPowerOscOn, 1'b1)
        complete_run;
    end
endmodule
`default_nettype wire
